// *** design/jccr_pkg.sv ***
// constants, register map and types for the jack configuration control registers
package jccr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] JCCR_OFS_OVERRIDE = 8'h19;
  localparam logic [7:0] JCCR_OFS_PULSE = 8'h1A;
  localparam logic [7:0] JCCR_OFS_EN_PRI = 8'h1D;
  localparam logic [7:0] JCCR_OFS_EN_SEC = 8'h1E;
  localparam logic [6:0] JCCR_SLAVE_ADDR = 7'h40;
  // ----------------------------------------
  // field positions and masks
  // ----------------------------------------
  localparam int JCCR_FORCE_N_BIT = 5;
  localparam int JCCR_POWER_BIT = 7;
  localparam int JCCR_RESTART_BIT = 6;
  localparam int JCCR_MIC_BIAS_BIT = 4;
  localparam int JCCR_MIC_AMP_BIT = 3;
  localparam int JCCR_BUTTON_BIT = 2;
  localparam int JCCR_LEFT_BIT = 7;
  localparam int JCCR_RIGHT_BIT = 6;
  localparam int JCCR_SLEW_DIS_BIT = 5;
  localparam int JCCR_ZC_DIS_BIT = 4;
  localparam int JCCR_FAST_BIT = 3;
  localparam int JCCR_SUPPLY_BIT = 2;
  localparam logic [7:0] JCCR_MASK_OVERRIDE = 8'h3F;
  localparam logic [7:0] JCCR_MASK_PULSE = 8'h3F;
  localparam logic [7:0] JCCR_MASK_EN_PRI = 8'hDC;
  localparam logic [7:0] JCCR_MASK_EN_SEC = 8'hFF;
  // power and restart bits, and the auto mode field, stay writable in auto mode
  localparam logic [7:0] JCCR_MASK_PRI_AUTO = 8'hC0;
  localparam logic [7:0] JCCR_MASK_SEC_AUTO = 8'h03;
  // ----------------------------------------
  // values after reset
  // ----------------------------------------
  localparam logic [7:0] JCCR_RST_OVERRIDE = 8'h20;
  localparam logic [7:0] JCCR_RST_PULSE = 8'h00;
  localparam logic [7:0] JCCR_RST_EN_PRI = 8'h00;
  localparam logic [7:0] JCCR_RST_EN_SEC = 8'h30;
  // ----------------------------------------
  // auto mode codes
  // ----------------------------------------
  localparam logic [1:0] JCCR_AUTO_HOST = 2'h0;
  localparam logic [1:0] JCCR_AUTO_AFTER_ON = 2'h1;
  localparam logic [1:0] JCCR_AUTO_ALWAYS = 2'h2;
  // ----------------------------------------
  // analog settings in their own units
  // ----------------------------------------
  localparam logic [8:0] JCCR_WIDTH_FIXED_US = 9'h00A;
  localparam logic [8:0] JCCR_WIDTH_US_0 = 9'h032;
  localparam logic [8:0] JCCR_WIDTH_US_1 = 9'h064;
  localparam logic [8:0] JCCR_WIDTH_US_2 = 9'h096;
  localparam logic [8:0] JCCR_WIDTH_US_3 = 9'h12C;
  localparam logic [7:0] JCCR_AMP_A_MV_0 = 8'h19;
  localparam logic [7:0] JCCR_AMP_A_MV_1 = 8'h32;
  localparam logic [7:0] JCCR_AMP_A_MV_2 = 8'h64;
  localparam logic [7:0] JCCR_AMP_A_MV_3 = 8'hC8;
  localparam logic [7:0] JCCR_AMP_B_MV_0 = 8'h25;
  localparam logic [7:0] JCCR_AMP_B_MV_1 = 8'h4B;
  localparam logic [7:0] JCCR_AMP_B_MV_2 = 8'h96;
  localparam logic [7:0] JCCR_AMP_B_MV_3 = 8'hDC;
  localparam logic [11:0] JCCR_POLL_SLOW_MS = 12'h7D0;
  localparam logic [11:0] JCCR_POLL_FAST_MS = 12'h14D;
  localparam logic [7:0] JCCR_ZC_TIMEOUT_MS = 8'h64;
  // ----------------------------------------
  // serial engine states
  // ----------------------------------------
  typedef enum logic [2:0] {
    JCCR_ST_IDLE,
    JCCR_ST_ADDR,
    JCCR_ST_ADDR_ACK,
    JCCR_ST_RX,
    JCCR_ST_RX_ACK,
    JCCR_ST_TX,
    JCCR_ST_TX_ACK
  } jccr_state_t;
endpackage : jccr_pkg

// *** design/jccr_pulse_decode.sv ***
// decodes the pulse test setup field into counts, widths and amplitudes
`timescale 1ns/1ps
module jccr_pulse_decode
  import jccr_pkg::*;
(
  // setup field
  input wire logic [7:0] pulse_setup,
  // decoded values
  output logic [3:0] pulse_count,
  output logic [8:0] width_us,
  output logic [8:0] width_fixed_us,
  output logic [7:0] amp_early_mv,
  output logic [7:0] amp_late_mv
);
  logic [1:0] cnt_sel;
  logic [1:0] wid_sel;
  logic [1:0] amp_sel;

  assign cnt_sel = pulse_setup[5:4];
  assign wid_sel = pulse_setup[3:2];
  assign amp_sel = pulse_setup[1:0];
  // 1, 3, 5, 7 pulses
  assign pulse_count = {1'b0, cnt_sel, 1'b1};
  assign width_fixed_us = JCCR_WIDTH_FIXED_US;

  always_comb
  begin
    case (wid_sel)
      2'h0: width_us = JCCR_WIDTH_US_0;
      2'h1: width_us = JCCR_WIDTH_US_1;
      2'h2: width_us = JCCR_WIDTH_US_2;
      default: width_us = JCCR_WIDTH_US_3;
    endcase
    case (amp_sel)
      2'h0:
      begin
        amp_early_mv = JCCR_AMP_A_MV_0;
        amp_late_mv = JCCR_AMP_B_MV_0;
      end
      2'h1:
      begin
        amp_early_mv = JCCR_AMP_A_MV_1;
        amp_late_mv = JCCR_AMP_B_MV_1;
      end
      2'h2:
      begin
        amp_early_mv = JCCR_AMP_A_MV_2;
        amp_late_mv = JCCR_AMP_B_MV_2;
      end
      default:
      begin
        amp_early_mv = JCCR_AMP_A_MV_3;
        amp_late_mv = JCCR_AMP_B_MV_3;
      end
    endcase
  end
endmodule : jccr_pulse_decode

// *** design/jccr_regs.sv ***
// serial slave and control register bank for the jack configuration block
`timescale 1ns/1ps
module jccr_regs
  import jccr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial port
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // detection engine status
  input wire logic detect_done,
  input wire logic [7:0] auto_pri_en,
  input wire logic [7:0] auto_sec_en,
  input wire logic [4:0] forced_blocks,
  // control outputs
  output logic power_on_ctl,
  output logic detect_restart,
  output logic force_active,
  output logic [4:0] force_code,
  output logic mic_bias_en,
  output logic mic_amp_en,
  output logic button_decoder_en,
  output logic left_channel_en,
  output logic right_channel_en,
  output logic gain_slew_en,
  output logic zero_cross_gate_en,
  output logic [11:0] poll_interval_ms,
  output logic [7:0] zero_cross_timeout_ms,
  output logic supply_switch_level_sel,
  output logic [1:0] auto_mode,
  output logic removal_sense_en,
  output logic [3:0] pulse_count,
  output logic [8:0] pulse_width_us,
  output logic [8:0] pulse_width_fixed_us,
  output logic [7:0] pulse_amp_early_mv,
  output logic [7:0] pulse_amp_late_mv
);
  // ----------------------------------------
  // bus line edge detection
  // ----------------------------------------
  logic scl_q, scl_d, sda_q, sda_d;
  logic scl_rise, scl_fall, start_ev, stop_ev;

  assign scl_d = scl;
  assign sda_d = sda_in;
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_ev = scl & scl_q & sda_q & ~sda_in;
  assign stop_ev = scl & scl_q & ~sda_q & sda_in;

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  jccr_state_t st_q, st_d;
  logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
  logic [3:0] bit_q, bit_d;
  logic ptr_set_q, ptr_set_d, oe_q, oe_d, seen_start_q, seen_start_d;
  logic wr_stb;
  logic [7:0] rd_data;
  logic [7:0] ovr_q, ovr_d, pls_q, pls_d, pri_q, pri_d, sec_q, sec_d;
  logic [7:0] pri_rd, sec_rd;
  logic auto_on;

  always_comb
  begin
    st_d = st_q;
    sh_d = sh_q;
    ptr_d = ptr_q;
    bit_d = bit_q;
    ptr_set_d = ptr_set_q;
    oe_d = oe_q;
    wr_stb = 1'b0;
    // a stop in the same high pulse as a start is not honoured
    seen_start_d = scl ? seen_start_q : 1'b0;
    if (start_ev)
    begin
      // repeated start keeps the session, only restarts the byte
      st_d = JCCR_ST_ADDR;
      bit_d = 4'h0;
      oe_d = 1'b0;
      seen_start_d = 1'b1;
    end
    else if (stop_ev && !seen_start_q)
    begin
      st_d = JCCR_ST_IDLE;
      oe_d = 1'b0;
    end
    else
    begin
      case (st_q)
        JCCR_ST_IDLE: oe_d = 1'b0;
        JCCR_ST_ADDR, JCCR_ST_RX:
        begin
          if (scl_rise)
          begin
            sh_d = {sh_q[6:0], sda_in};
            bit_d = bit_q + 4'h1;
          end
          if (scl_fall && bit_q == 4'h8)
          begin
            bit_d = 4'h0;
            if (st_q == JCCR_ST_ADDR)
            begin
              if (sh_q[7:1] == JCCR_SLAVE_ADDR)
              begin
                oe_d = 1'b1;
                st_d = JCCR_ST_ADDR_ACK;
                ptr_set_d = sh_q[0] ? ptr_set_q : 1'b0;
              end
              else
                st_d = JCCR_ST_IDLE;
            end
            else
            begin
              oe_d = 1'b1;
              st_d = JCCR_ST_RX_ACK;
              if (!ptr_set_q)
              begin
                ptr_d = sh_q;
                ptr_set_d = 1'b1;
              end
              else
              begin
                wr_stb = 1'b1;
                ptr_d = ptr_q + 8'h01;
              end
            end
          end
        end
        JCCR_ST_ADDR_ACK:
          if (scl_fall)
          begin
            if (sh_q[0])
            begin
              st_d = JCCR_ST_TX;
              sh_d = rd_data;
              oe_d = ~rd_data[7];
            end
            else
            begin
              st_d = JCCR_ST_RX;
              oe_d = 1'b0;
            end
          end
        JCCR_ST_RX_ACK:
          if (scl_fall)
          begin
            st_d = JCCR_ST_RX;
            oe_d = 1'b0;
          end
        JCCR_ST_TX:
        begin
          if (scl_rise)
            bit_d = bit_q + 4'h1;
          if (scl_fall)
          begin
            if (bit_q == 4'h8)
            begin
              bit_d = 4'h0;
              oe_d = 1'b0;
              st_d = JCCR_ST_TX_ACK;
              ptr_d = ptr_q + 8'h01;
            end
            else
            begin
              sh_d = {sh_q[6:0], 1'b0};
              oe_d = ~sh_q[6];
            end
          end
        end
        JCCR_ST_TX_ACK:
        begin
          // master nack releases the line until stop
          if (scl_rise && sda_in)
            st_d = JCCR_ST_IDLE;
          else if (scl_fall)
          begin
            st_d = JCCR_ST_TX;
            sh_d = rd_data;
            oe_d = ~rd_data[7];
          end
        end
        default: st_d = JCCR_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  assign auto_on = sec_q[1:0] == JCCR_AUTO_AFTER_ON || sec_q[1:0] == JCCR_AUTO_ALWAYS;
  // in auto mode block enables report what the device chose
  assign pri_rd = auto_on ? ((pri_q & JCCR_MASK_PRI_AUTO) | (auto_pri_en & ~JCCR_MASK_PRI_AUTO & JCCR_MASK_EN_PRI))
                          : pri_q;
  assign sec_rd = auto_on ? ((sec_q & ~8'hC0) | (auto_sec_en & 8'hC0)) : sec_q;

  always_comb
  begin
    case (ptr_q)
      JCCR_OFS_OVERRIDE: rd_data = ovr_q;
      JCCR_OFS_PULSE: rd_data = pls_q;
      JCCR_OFS_EN_PRI: rd_data = pri_rd;
      JCCR_OFS_EN_SEC: rd_data = sec_rd;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb
  begin
    ovr_d = ovr_q;
    pls_d = pls_q;
    pri_d = pri_q;
    sec_d = sec_q;
    if (wr_stb)
    begin
      case (ptr_q)
        JCCR_OFS_OVERRIDE: ovr_d = sh_q & JCCR_MASK_OVERRIDE;
        JCCR_OFS_PULSE: pls_d = sh_q & JCCR_MASK_PULSE;
        JCCR_OFS_EN_PRI:
          if (auto_on)
            pri_d = (pri_q & ~JCCR_MASK_PRI_AUTO) | (sh_q & JCCR_MASK_PRI_AUTO);
          else
            pri_d = sh_q & JCCR_MASK_EN_PRI;
        JCCR_OFS_EN_SEC:
          if (auto_on)
            sec_d = (sec_q & ~JCCR_MASK_SEC_AUTO) | (sh_q & JCCR_MASK_SEC_AUTO);
          else
            sec_d = sh_q & JCCR_MASK_EN_SEC;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // restart sequence low, high, low
  // ----------------------------------------
  logic rst_armed_q, rst_armed_d, restart_q, restart_d;

  always_comb
  begin
    rst_armed_d = rst_armed_q;
    restart_d = 1'b0;
    if (pri_q[JCCR_RESTART_BIT])
      rst_armed_d = 1'b1;
    else if (rst_armed_q)
    begin
      rst_armed_d = 1'b0;
      restart_d = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      st_q <= JCCR_ST_IDLE;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      bit_q <= 4'h0;
      ptr_set_q <= 1'b0;
      oe_q <= 1'b0;
      seen_start_q <= 1'b0;
      ovr_q <= JCCR_RST_OVERRIDE;
      pls_q <= JCCR_RST_PULSE;
      pri_q <= JCCR_RST_EN_PRI;
      sec_q <= JCCR_RST_EN_SEC;
      rst_armed_q <= 1'b0;
      restart_q <= 1'b0;
    end
    else
    begin
      scl_q <= scl_d;
      sda_q <= sda_d;
      st_q <= st_d;
      sh_q <= sh_d;
      ptr_q <= ptr_d;
      bit_q <= bit_d;
      ptr_set_q <= ptr_set_d;
      oe_q <= oe_d;
      seen_start_q <= seen_start_d;
      ovr_q <= ovr_d;
      pls_q <= pls_d;
      pri_q <= pri_d;
      sec_q <= sec_d;
      rst_armed_q <= rst_armed_d;
      restart_q <= restart_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever pulls low
  assign sda_out = 1'b0;
  assign sda_oe_n = ~oe_q;
  assign detect_restart = restart_q;
  assign power_on_ctl = pri_q[JCCR_POWER_BIT];
  assign force_active = ~ovr_q[JCCR_FORCE_N_BIT];
  assign force_code = ovr_q[4:0];
  // forcing turns needed blocks on regardless of enable registers
  assign mic_bias_en = force_active ? forced_blocks[4] : pri_rd[JCCR_MIC_BIAS_BIT];
  assign mic_amp_en = force_active ? forced_blocks[3] : pri_rd[JCCR_MIC_AMP_BIT];
  assign button_decoder_en = force_active ? forced_blocks[2] : pri_rd[JCCR_BUTTON_BIT];
  assign left_channel_en = force_active ? forced_blocks[1] : sec_rd[JCCR_LEFT_BIT];
  assign right_channel_en = force_active ? forced_blocks[0] : sec_rd[JCCR_RIGHT_BIT];
  assign gain_slew_en = ~sec_q[JCCR_SLEW_DIS_BIT];
  assign zero_cross_gate_en = ~sec_q[JCCR_ZC_DIS_BIT];
  assign zero_cross_timeout_ms = JCCR_ZC_TIMEOUT_MS;
  assign poll_interval_ms = sec_q[JCCR_FAST_BIT] ? JCCR_POLL_FAST_MS : JCCR_POLL_SLOW_MS;
  assign supply_switch_level_sel = sec_q[JCCR_SUPPLY_BIT];
  assign auto_mode = sec_q[1:0];
  assign removal_sense_en = detect_done & (mic_bias_en | left_channel_en | right_channel_en);

  jccr_pulse_decode u_decode (
    .pulse_setup(pls_q),
    .pulse_count(pulse_count),
    .width_us(pulse_width_us),
    .width_fixed_us(pulse_width_fixed_us),
    .amp_early_mv(pulse_amp_early_mv),
    .amp_late_mv(pulse_amp_late_mv)
  );
endmodule : jccr_regs

// *** sim/jccr_host_model.sv ***
// two-wire bus master standing in for the host controller
`timescale 1ns/1ps
module jccr_host_model
(
  // clock of the bench
  input wire logic clk,
  // two-wire bus
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // ----------------------------------------
  // bit timing
  // ----------------------------------------
  // far above the bus limit to keep the run short; the port samples every clk
  localparam int HALF = 8;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // data moves only while the clock is low, then is sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic s);
    sda_low <= ~b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    s = sda_line;
    scl <= 1'b0;
    tick(2);
  endtask : put_bit
  // ----------------------------------------
  // framing
  // ----------------------------------------
  // also serves as repeated start; no stop follows within the same high phase
  task automatic start_cond();
    sda_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
    tick(2);
  endtask : start_cond
  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask : stop_cond
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(d[i], s);
    put_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
  // the last byte gets a not-acknowledge, the caller then stops
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(1'b1, d[i]);
    put_bit(last, s);
  endtask : get_byte
endmodule : jccr_host_model

// *** sim/jccr_regs_assertions.sv ***
// port-level checks for the jack configuration register bank
`timescale 1ns/1ps
module jccr_regs_assertions
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial port
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // detection inputs
  input wire logic detect_done,
  input wire logic [4:0] forced_blocks,
  // controls
  input wire logic power_on_ctl,
  input wire logic detect_restart,
  input wire logic force_active,
  input wire logic mic_bias_en,
  input wire logic left_channel_en,
  input wire logic right_channel_en,
  input wire logic [11:0] poll_interval_ms,
  input wire logic [7:0] zero_cross_timeout_ms,
  input wire logic [1:0] auto_mode,
  input wire logic removal_sense_en,
  input wire logic [3:0] pulse_count,
  input wire logic [8:0] pulse_width_fixed_us
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_count_odd: assert property (pulse_count[0] && pulse_count <= 4'h7)
    else $error("pulse count is not 1, 3, 5 or 7");
  a_fixed_width: assert property (pulse_width_fixed_us == 9'h00A)
    else $error("fixed pulse width is not 10 us");
  a_zc_timeout: assert property (zero_cross_timeout_ms == 8'h64)
    else $error("zero-cross timeout is not 100 ms");
  a_poll_choice: assert property (poll_interval_ms == 12'h7D0 || poll_interval_ms == 12'h14D)
    else $error("poll interval is neither 2000 nor 333 ms");
  a_removal_gate: assert property (removal_sense_en ==
    (detect_done && (mic_bias_en || left_channel_en || right_channel_en)))
    else $error("removal sensing does not follow detection and block enables");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("data pin drives a high level");
  a_steady_high: assert property (scl && $past(scl) |-> $stable(sda_oe_n))
    else $error("device moved data while the bus clock was high");
  a_ack_low: assert property ($fell(sda_oe_n) |-> !scl && !$past(scl))
    else $error("device pulled data low outside a clock-low phase");
  a_restart_single: assert property (detect_restart |=> !detect_restart)
    else $error("detection restart lasted more than one cycle");
  a_reset_state: assert property (!$past(rst_n) |-> sda_oe_n && !force_active && !power_on_ctl && auto_mode == 2'h0)
    else $error("state after reset is wrong");
  a_forced_blocks: assert property ((force_active && forced_blocks[4] && forced_blocks[1]) [*3] |-> mic_bias_en && left_channel_en)
    else $error("forced blocks not turned on");
  // ----------------------------------------
  // cover
  // ----------------------------------------
  c_restart: cover property (detect_restart);
  c_forced: cover property (force_active && mic_bias_en);
  c_ack: cover property (!sda_oe_n && scl);
endmodule : jccr_regs_assertions
bind jccr_regs jccr_regs_assertions u_jccr_regs_assertions (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .detect_done(detect_done), .forced_blocks(forced_blocks), .power_on_ctl(power_on_ctl),
  .detect_restart(detect_restart), .force_active(force_active), .mic_bias_en(mic_bias_en),
  .left_channel_en(left_channel_en), .right_channel_en(right_channel_en),
  .poll_interval_ms(poll_interval_ms), .zero_cross_timeout_ms(zero_cross_timeout_ms),
  .auto_mode(auto_mode), .removal_sense_en(removal_sense_en), .pulse_count(pulse_count),
  .pulse_width_fixed_us(pulse_width_fixed_us)
);

// *** sim/test_jccr_regs.sv ***
// self-checking bench for the jack configuration register bank
`timescale 1ns/1ps
module test_jccr_regs;
  import jccr_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic detect_done = 1'b0;
  logic [7:0] auto_pri_en = 8'h08;
  logic [7:0] auto_sec_en = 8'hC0;
  logic [4:0] forced_blocks = 5'h12;
  logic scl, sda_in, sda_low, sda_out, sda_oe_n, power_on_ctl, detect_restart, force_active;
  logic mic_bias_en, mic_amp_en, button_decoder_en, left_channel_en, right_channel_en;
  logic gain_slew_en, zero_cross_gate_en, supply_switch_level_sel, removal_sense_en;
  logic [4:0] force_code;
  logic [11:0] poll_interval_ms;
  logic [7:0] zero_cross_timeout_ms, pulse_amp_early_mv, pulse_amp_late_mv;
  logic [1:0] auto_mode;
  logic [3:0] pulse_count;
  logic [8:0] pulse_width_us, pulse_width_fixed_us;
  int err_total = 0;
  int checks = 0;
  int restarts = 0;
  localparam logic [11:0] CNT [4] = '{12'h001, 12'h003, 12'h005, 12'h007};
  localparam logic [11:0] WID [4] = '{12'h032, 12'h064, 12'h096, 12'h12C};
  localparam logic [11:0] AMA [4] = '{12'h019, 12'h032, 12'h064, 12'h0C8};
  localparam logic [11:0] AMB [4] = '{12'h025, 12'h04B, 12'h096, 12'h0DC};
  always #2 clk = ~clk;
  // pull-up on the data line; either party may pull it low
  assign sda_in = ~(sda_low | ~sda_oe_n);
  always @(posedge clk) if (detect_restart === 1'b1) restarts++;
  jccr_regs u_jccr_regs (
    .clk(clk), .rst_n(rst_n), .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .detect_done(detect_done), .auto_pri_en(auto_pri_en), .auto_sec_en(auto_sec_en),
    .forced_blocks(forced_blocks), .power_on_ctl(power_on_ctl), .detect_restart(detect_restart),
    .force_active(force_active), .force_code(force_code), .mic_bias_en(mic_bias_en),
    .mic_amp_en(mic_amp_en), .button_decoder_en(button_decoder_en), .left_channel_en(left_channel_en),
    .right_channel_en(right_channel_en), .gain_slew_en(gain_slew_en),
    .zero_cross_gate_en(zero_cross_gate_en), .poll_interval_ms(poll_interval_ms),
    .zero_cross_timeout_ms(zero_cross_timeout_ms), .supply_switch_level_sel(supply_switch_level_sel),
    .auto_mode(auto_mode), .removal_sense_en(removal_sense_en), .pulse_count(pulse_count),
    .pulse_width_us(pulse_width_us), .pulse_width_fixed_us(pulse_width_fixed_us),
    .pulse_amp_early_mv(pulse_amp_early_mv), .pulse_amp_late_mv(pulse_amp_late_mv)
  );
  jccr_host_model u_jccr_host_model (.clk(clk), .scl(scl), .sda_low(sda_low), .sda_line(sda_in));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic reg_write(input logic [7:0] ofs, input logic [7:0] d);
    logic a0, a1, a2;
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h80, a0);
    u_jccr_host_model.send_byte(ofs, a1);
    u_jccr_host_model.send_byte(d, a2);
    u_jccr_host_model.stop_cond();
    chk("write ack", 12'h007, 12'({a0, a1, a2}));
  endtask : reg_write
  task automatic rd_chk(input logic [7:0] ofs, input logic [7:0] exp);
    logic a0, a1, a2;
    logic [7:0] d;
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h80, a0);
    u_jccr_host_model.send_byte(ofs, a1);
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h81, a2);
    u_jccr_host_model.get_byte(1'b1, d);
    u_jccr_host_model.stop_cond();
    chk("read ack", 12'h007, 12'({a0, a1, a2}));
    chk("register", 12'(exp), 12'(d));
  endtask : rd_chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    logic a;
    logic [7:0] b0, b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(8'h19, 8'h20);
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h1D, 8'h00);
    rd_chk(8'h1E, 8'h30);
    for (int c = 0; c < 4; c++)
    begin
      reg_write(8'h1A, {2'b11, 2'(c), 2'(c), 2'(c)});
      rd_chk(8'h1A, {2'b00, 2'(c), 2'(c), 2'(c)});
      chk("pulse_count", CNT[c], 12'(pulse_count));
      chk("pulse_width", WID[c], 12'(pulse_width_us));
      chk("fixed_width", 12'h00A, 12'(pulse_width_fixed_us));
      chk("amp_early", AMA[c], 12'(pulse_amp_early_mv));
      chk("amp_late", AMB[c], 12'(pulse_amp_late_mv));
    end
    // one frame fills two neighbouring registers
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h80, a);
    u_jccr_host_model.send_byte(8'h19, a);
    u_jccr_host_model.send_byte(8'h05, a);
    u_jccr_host_model.send_byte(8'hC0, a);
    u_jccr_host_model.stop_cond();
    chk("data ack", 12'h001, 12'(a));
    rd_chk(8'h1A, 8'h00);
    rd_chk(8'h19, 8'h05);
    chk("force_code", 12'h005, 12'(force_code));
    chk("forced", 12'h01A, 12'({force_active, mic_bias_en, mic_amp_en, left_channel_en, right_channel_en}));
    // a stop in mid-byte abandons the write
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h80, a);
    u_jccr_host_model.send_byte(8'h1A, a);
    repeat (3) u_jccr_host_model.put_bit(1'b1, a);
    u_jccr_host_model.stop_cond();
    rd_chk(8'h1A, 8'h00);
    reg_write(8'h19, 8'hFF);
    rd_chk(8'h19, 8'h3F);
    chk("force off", 12'h000, 12'({force_active, mic_bias_en, left_channel_en}));
    reg_write(8'h1D, 8'hFF);
    rd_chk(8'h1D, 8'hDC);
    chk("primary", 12'h00F, 12'({power_on_ctl, mic_bias_en, mic_amp_en, button_decoder_en}));
    reg_write(8'h1D, 8'h9C);
    reg_write(8'h1D, 8'h9C);
    chk("restarts", 12'h001, 12'(restarts));
    reg_write(8'h1E, 8'hFC);
    rd_chk(8'h1E, 8'hFC);
    // a read frame runs on over two neighbouring registers with a master acknowledge between
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h80, a);
    u_jccr_host_model.send_byte(8'h1D, a);
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h81, a);
    u_jccr_host_model.get_byte(1'b0, b0);
    u_jccr_host_model.get_byte(1'b1, b1);
    u_jccr_host_model.stop_cond();
    chk("burst first", 12'h09C, 12'(b0));
    chk("burst second", 12'h0FC, 12'(b1));
    chk("secondary", 12'h019, 12'({left_channel_en, right_channel_en, gain_slew_en, zero_cross_gate_en,
      supply_switch_level_sel}));
    chk("fast poll", 12'h14D, poll_interval_ms);
    reg_write(8'h1E, 8'hC0);
    chk("secondary", 12'h01E, 12'({left_channel_en, right_channel_en, gain_slew_en, zero_cross_gate_en,
      supply_switch_level_sel}));
    chk("slow poll", 12'h7D0, poll_interval_ms);
    chk("zc timeout", 12'h064, 12'(zero_cross_timeout_ms));
    chk("removal idle", 12'h000, 12'(removal_sense_en));
    detect_done <= 1'b1;
    repeat (3) @(posedge clk);
    chk("removal armed", 12'h001, 12'(removal_sense_en));
    for (int m = 1; m < 3; m++)
    begin
      reg_write(8'h1E, {6'h00, 2'(m)});
      rd_chk(8'h1E, {6'h30, 2'(m)});
      chk("auto_mode", 12'(m), 12'(auto_mode));
    end
    reg_write(8'h1D, 8'h00);
    rd_chk(8'h1D, 8'h08);
    chk("power", 12'h000, 12'(power_on_ctl));
    reg_write(8'h1E, 8'h00);
    reg_write(8'h1E, 8'h00);
    rd_chk(8'h1E, 8'h00);
    u_jccr_host_model.start_cond();
    u_jccr_host_model.send_byte(8'h82, a);
    u_jccr_host_model.stop_cond();
    chk("foreign address", 12'h000, 12'(a));
    reg_write(8'h1B, 8'hFF);
    rd_chk(8'h1B, 8'h00);
    stop_test();
  end
  // the sequence needs about 25000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    err_total++;
    stop_test();
  end
endmodule : test_jccr_regs
